//--- logic/cncc_cfg.svh
// constants of the coax network crate controller and its slave node
// assumes a 40 MHz core clock; included by both ends of the line
`ifndef CNCC_CFG_SVH
`define CNCC_CFG_SVH
// -------------------------------------------------------------
// timing
// -------------------------------------------------------------
`define CNCC_CLK_NS    25
`define CNCC_BAUD_KBD  1000
`define CNCC_NODE_KHZ  (3 * `CNCC_BAUD_KBD)
`define CNCC_BIT_CYC   (1000000 / (`CNCC_BAUD_KBD * `CNCC_CLK_NS))
`define CNCC_GAP_CYC   (3 * `CNCC_BIT_CYC)
`define CNCC_RST_US    3000
`define CNCC_RST_CYC   (`CNCC_RST_US * 1000 / `CNCC_CLK_NS)
`define CNCC_TMO_MS    500
`define CNCC_TMO_CYC   (`CNCC_TMO_MS * 1000000 / `CNCC_CLK_NS)
`define CNCC_DEB_US    100
`define CNCC_DEB_CYC   (`CNCC_DEB_US * 1000 / `CNCC_CLK_NS)
// -------------------------------------------------------------
// sizes, function codes, error words
// -------------------------------------------------------------
`define CNCC_BUF_WORDS 256
`define CNCC_PKT_BYTES 512
`define CNCC_F_READ    5'h00
`define CNCC_F_TEST    5'h08
`define CNCC_F_RESET   5'h09
`define CNCC_F_WRITE   5'h10
`define CNCC_F_START   5'h11
`define CNCC_F_LAMOFF  5'h18
`define CNCC_F_LAMON   5'h1a
`define CNCC_ERR_TMO   16'hffff
`define CNCC_ERR_HDR   16'hfffe
`define CNCC_ERR_EMPTY 16'hfffd
`define CNCC_RSP_MARK  8'ha5
`endif

//--- logic/cncc_pkg.sv
// types shared by the crate controller and the slave node
// assumes nothing beyond a SystemVerilog compiler
package cncc_pkg;
  typedef enum logic [2:0] {
    ST_RESTART = 3'h0,
    ST_IDLE    = 3'h1,
    ST_TX      = 3'h2,
    ST_WAIT    = 3'h3,
    ST_RX      = 3'h4
  } cncc_state_t;
  typedef enum logic [0:0] {
    SL_LISTEN = 1'h0,
    SL_REPLY  = 1'h1
  } cncc_slv_state_t;
endpackage

//--- logic/cncc_line_if.sv
// shared coax line between the controller and one slave node
// assumes both ends drive low only through their enables
`timescale 1ns/1ps
interface cncc_line_if;
  logic m_oe_n;
  logic m_dout;
  logic s_oe_n;
  logic s_dout;
  logic line;
  // wired line, idles high when nobody drives
  assign line = (m_oe_n | m_dout) & (s_oe_n | s_dout);
  modport master (output m_oe_n, output m_dout, input line);
  modport slave  (output s_oe_n, output s_dout, input line);
endinterface

//--- logic/cncc_slave.sv
// slave network node: hears every packet, answers when addressed
// assumes the master leaves the line clear before it expects a reply
`timescale 1ns/1ps
`include "cncc_cfg.svh"
module cncc_slave import cncc_pkg::*; #(
  parameter int PKT_MAX = `CNCC_PKT_BYTES
) (
  // clock, reset, enable
  input  wire logic       CORE_CLK_I,
  input  wire logic       RST_B_I,
  input  wire logic       CE_I,
  // node address
  input  wire logic [7:0] SLV_ADDR_I,
  // user side
  output logic [7:0]      RX_BYTE_O,
  output logic            RX_STB_O,
  output logic            REPLY_O,
  // network line
  cncc_line_if.slave      line
);
  localparam logic [5:0] BIT_M1 = 6'(`CNCC_BIT_CYC - 1);
  localparam logic [5:0] HALF   = 6'(`CNCC_BIT_CYC / 2 - 1);
  localparam logic [7:0] GAP    = 8'(`CNCC_GAP_CYC);
  typedef struct packed {
    cncc_slv_state_t st;
    logic            ln_s1;
    logic            ln_s2;
    logic [7:0]      idle;
    logic            rbusy;
    logic [5:0]      rbt;
    logic [3:0]      rbitc;
    logic [7:0]      rsh;
    logic [9:0]      cnt;
    logic            addr_ok;
    logic            stb;
    logic [7:0]      rbyte;
    logic            tbusy;
    logic [5:0]      bt;
    logic [3:0]      bitc;
    logic [9:0]      sh;
    logic [9:0]      idx;
    logic            oe_n;
    logic            dout;
    logic            reply;
  } cncc_slv_st_t;
  cncc_slv_st_t s;
  cncc_slv_st_t n;
  logic [7:0]   mem [PKT_MAX];
  logic         we;
  logic         clr;
  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  assign clr = s.idle == GAP;
  always_comb begin
    n = s;
    we = 1'b0;
    n.stb = 1'b0;
    n.ln_s1 = line.line;
    n.ln_s2 = s.ln_s1;
    if (!s.ln_s2) begin
      n.idle = '0;
    end else if (!clr) begin
      n.idle = s.idle + 8'h01;
    end
    if (s.st == SL_LISTEN) begin
      if (!s.rbusy) begin
        if (!s.ln_s2) begin
          n.rbusy = 1'b1;
          n.rbt = HALF;
          n.rbitc = '0;
        end else if (clr && s.cnt != 10'h000) begin
          n.cnt = '0;
          if (s.addr_ok) begin
            n.st = SL_REPLY;
            n.cnt = s.cnt;
            n.idx = '0;
          end
        end
      end else if (s.rbt != 6'h00) begin
        n.rbt = s.rbt - 6'h01;
      end else begin
        n.rbt = BIT_M1;
        n.rbitc = s.rbitc + 4'h1;
        if (s.rbitc == 4'h0 && s.ln_s2) begin
          n.rbusy = 1'b0;
        end else if (s.rbitc != 4'h0 && s.rbitc != 4'h9) begin
          n.rsh = {s.ln_s2, s.rsh[7:1]};
        end else if (s.rbitc == 4'h9) begin
          n.rbusy = 1'b0;
          n.stb = 1'b1;
          n.rbyte = s.rsh;
          if (s.cnt == 10'h000) begin
            n.addr_ok = s.rsh == SLV_ADDR_I;
          end
          if (s.cnt < 10'(PKT_MAX)) begin
            we = 1'b1;
            n.cnt = s.cnt + 10'h001;
          end
        end
      end
    end else if (s.tbusy) begin
      if (s.bt != 6'h00) begin
        n.bt = s.bt - 6'h01;
      end else begin
        n.bt = BIT_M1;
        n.sh = {1'b1, s.sh[9:1]};
        n.bitc = s.bitc + 4'h1;
        n.tbusy = s.bitc != 4'h9;
      end
    end else if (s.idx == s.cnt) begin
      n.st = SL_LISTEN;
      n.cnt = '0;
      n.addr_ok = 1'b0;
    end else begin
      n.tbusy = 1'b1;
      n.bt = BIT_M1;
      n.bitc = '0;
      n.idx = s.idx + 10'h001;
      if (s.idx == 10'h000) begin
        n.sh = {1'b1, `CNCC_RSP_MARK, 1'b0};
      end else begin
        n.sh = {1'b1, mem[s.idx[8:0]], 1'b0};
      end
    end
    n.oe_n = ~n.tbusy;
    n.dout = n.sh[0];
    n.reply = n.st == SL_REPLY; // registered so the output is a flop
  end
  // -------------------------------------------------------------
  // registers and packet store
  // -------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      s <= '0;
      s.ln_s1 <= 1'b1;
      s.ln_s2 <= 1'b1;
      s.oe_n <= 1'b1;
      s.dout <= 1'b1;
    end else if (CE_I) begin
      s <= n;
    end
  end
  always_ff @(posedge CORE_CLK_I) begin
    if (CE_I && we) begin
      mem[s.cnt[8:0]] <= s.rsh;
    end
  end
  assign RX_BYTE_O = s.rbyte;
  assign RX_STB_O = s.stb;
  assign REPLY_O = s.reply;
  assign line.s_oe_n = s.oe_n;
  assign line.s_dout = s.dout;
endmodule

//--- logic/cncc_ctrl.sv
// crate controller end: dataway functions, word buffers, network master
// assumes function strobes come from logic on the same clock
`timescale 1ns/1ps
`include "cncc_cfg.svh"
// Behaviour
// - separate 16-bit transmit and receive word buffers
// - words travel as two bytes, high first
// - failed operations leave error word in receive buffer
// - look-at-me once response ready, if enabled
// - button restart clears, disables, ignores for 3ms
// - activity indicator on while node is active
// - half duplex: drive line only while sending
// - first byte waits for clear line
// - only addressed slave replies
// - master starts every transaction
// - packets never exceed 512 bytes
// - node stores hold 512 bytes each
// - bit time is three node reference ticks
// - node events: sent, received, receive store emptied
// - transmit mode serialises transmit buffer bytes
// - receive mode stores incoming packet automatically
// - restart ignores commands, clears, waits clear line
// - write stores word, Q=0 busy or full
// - start on empty buffer stores empty error
// - timeout and bad-header error words
// - read gives words with Q; last read clears look-at-me
module cncc_ctrl import cncc_pkg::*; #(
  parameter int DEPTH   = `CNCC_BUF_WORDS,
  parameter int RST_CYC = `CNCC_RST_CYC,
  parameter int TMO_CYC = `CNCC_TMO_CYC,
  parameter int PKT_MAX = `CNCC_PKT_BYTES
) (
  // clock, reset, enable
  input  wire logic        CORE_CLK_I,
  input  wire logic        RST_B_I,
  input  wire logic        CE_I,
  // dataway functions
  input  wire logic        CMD_STB_I,
  input  wire logic [4:0]  FUNC_I,
  input  wire logic [15:0] WDATA_I,
  input  wire logic        CRATE_CLR_I,
  output logic             DONE_O,
  output logic             Q_O,
  output logic [15:0]      RDATA_O,
  output logic             LAM_O,
  // front panel
  input  wire logic        PANEL_BTN_I,
  output logic             LED_O,
  // network line
  cncc_line_if.master      line
);
  localparam int AW = $clog2(DEPTH);
  localparam int TW = $clog2((TMO_CYC > RST_CYC ? TMO_CYC : RST_CYC) + 1);
  localparam logic [5:0]    BIT_M1 = 6'(`CNCC_BIT_CYC - 1);
  localparam logic [5:0]    HALF   = 6'(`CNCC_BIT_CYC / 2 - 1);
  localparam logic [7:0]    GAP    = 8'(`CNCC_GAP_CYC);
  localparam logic [11:0]   DEB_M1 = 12'(`CNCC_DEB_CYC - 1);
  localparam logic [TW-1:0] RST_M1 = TW'(RST_CYC - 1);
  localparam logic [TW-1:0] TMO_M1 = TW'(TMO_CYC - 1);
  typedef struct packed {
    cncc_state_t st;
    logic [TW-1:0] tmr;
    logic [11:0]   deb;
    logic          btn_s1;
    logic          btn_s2;
    logic          btn_db;
    logic          ln_s1;
    logic          ln_s2;
    logic [7:0]    idle;
    logic          lam_en;
    logic          rdy;
    logic          lam;
    logic          led;
    logic          done;
    logic          q;
    logic [15:0]   rdata;
    logic [AW:0]   twp;
    logic [AW:0]   trp;
    logic [AW:0]   rwp;
    logic [AW:0]   rrp;
    logic [1:0]    bcnt;
    logic [15:0]   b0;
    logic [15:0]   b1;
    logic          tbusy;
    logic          lo_nxt;
    logic          sent;
    logic [9:0]    sh;
    logic [3:0]    bitc;
    logic [5:0]    bt;
    logic          rbusy;
    logic [3:0]    rbitc;
    logic [5:0]    rbt;
    logic [7:0]    rsh;
    logic [7:0]    hi;
    logic          first;
    logic          hdr_bad;
    logic          have_hi;
    logic [9:0]    nbytes;
    logic          oe_n;
    logic          dout;
  } cncc_dev_st_t;
  cncc_dev_st_t s;
  cncc_dev_st_t n;
  logic [15:0] tx_mem [DEPTH];
  logic [15:0] rx_mem [DEPTH];
  logic        tx_we;
  logic        rx_we;
  logic [AW:0] rx_wa;
  logic [15:0] rx_wd;
  logic        push;
  logic        pop;
  logic        btn_hit;
  logic        rst_req;
  logic        clr;
  logic        busy;
  logic        tx_empty;
  logic        tx_full;
  logic        rx_empty;
  // -------------------------------------------------------------
  // buffer levels and line state
  // -------------------------------------------------------------
  assign clr = s.idle == GAP;
  assign busy = s.st == ST_TX || s.st == ST_WAIT || s.st == ST_RX;
  assign tx_empty = s.twp == s.trp;
  assign tx_full = s.twp == {~s.trp[AW], s.trp[AW-1:0]};
  assign rx_empty = s.rwp == s.rrp;
  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb begin
    n = s;
    tx_we = 1'b0;
    rx_we = 1'b0;
    rx_wa = s.rwp;
    rx_wd = '0;
    push = 1'b0;
    pop = 1'b0;
    btn_hit = 1'b0;
    n.done = 1'b0;
    // button and line synchronisers, debounce
    n.btn_s1 = PANEL_BTN_I;
    n.btn_s2 = s.btn_s1;
    n.ln_s1 = line.line;
    n.ln_s2 = s.ln_s1;
    if (s.btn_s2 == s.btn_db) begin
      n.deb = '0;
    end else if (s.deb == DEB_M1) begin
      n.deb = '0;
      n.btn_db = s.btn_s2;
      btn_hit = s.btn_s2;
    end else begin
      n.deb = s.deb + 12'h001;
    end
    if (!s.ln_s2) begin
      n.idle = '0;
    end else if (!clr) begin
      n.idle = s.idle + 8'h01;
    end
    // dataway functions, answered one cycle later
    if (CMD_STB_I) begin
      n.done = 1'b1;
      n.q = 1'b0;
      if (s.st != ST_RESTART) begin
        case (FUNC_I)
          `CNCC_F_READ: begin
            if (s.rdy && !rx_empty) begin
              n.q = 1'b1;
              n.rdata = rx_mem[s.rrp[AW-1:0]];
              n.rrp = s.rrp + 1'b1;
              n.rdy = n.rrp != s.rwp;
            end
          end
          `CNCC_F_TEST: n.q = s.lam;
          `CNCC_F_RESET: n.q = 1'b1;
          `CNCC_F_WRITE: begin
            if (!busy && !tx_full) begin
              tx_we = 1'b1;
              n.twp = s.twp + 1'b1;
              n.q = 1'b1;
            end
          end
          `CNCC_F_START: begin
            if (!busy) begin
              n.q = 1'b1;
              n.rrp = '0;
              n.rdy = 1'b0;
              if (tx_empty) begin
                rx_we = 1'b1;
                rx_wa = '0;
                rx_wd = `CNCC_ERR_EMPTY;
                n.rwp = (AW+1)'(1);
                n.rdy = 1'b1;
              end else begin
                n.rwp = '0;
                n.st = ST_TX;
                n.sent = 1'b0;
                n.lo_nxt = 1'b0;
              end
            end
          end
          `CNCC_F_LAMOFF: begin
            n.lam_en = 1'b0;
            n.q = 1'b1;
          end
          `CNCC_F_LAMON: begin
            n.lam_en = 1'b1;
            n.q = 1'b1;
          end
          default: n.q = 1'b0;
        endcase
      end
    end
    // transmit mode: buffer to two-entry queue to serialiser
    if (s.st == ST_TX) begin
      push = !tx_empty && s.bcnt != 2'h2;
      if (s.tbusy) begin
        if (s.bt != 6'h00) begin
          n.bt = s.bt - 6'h01;
        end else begin
          n.bt = BIT_M1;
          n.sh = {1'b1, s.sh[9:1]};
          n.bitc = s.bitc + 4'h1;
          if (s.bitc == 4'h9) begin
            n.tbusy = 1'b0;
            pop = !s.lo_nxt;
          end
        end
      end else if (s.bcnt != 2'h0 && (s.sent || clr)) begin
        n.tbusy = 1'b1;
        n.sent = 1'b1;
        n.bitc = '0;
        n.bt = BIT_M1;
        n.lo_nxt = ~s.lo_nxt;
        if (s.lo_nxt) begin
          n.sh = {1'b1, s.b0[7:0], 1'b0};
        end else begin
          n.sh = {1'b1, s.b0[15:8], 1'b0};
        end
      end else if (s.bcnt == 2'h0 && tx_empty && s.sent) begin
        n.st = ST_WAIT;
        n.trp = '0;
        n.twp = '0;
        n.tmr = '0;
        n.first = 1'b1;
        n.hdr_bad = 1'b0;
        n.have_hi = 1'b0;
        n.nbytes = '0;
      end
    end
    if (pop) begin
      n.b0 = s.b1;
      n.bcnt = s.bcnt - 2'h1;
    end
    if (push) begin
      if (n.bcnt == 2'h0) begin
        n.b0 = tx_mem[s.trp[AW-1:0]];
      end else begin
        n.b1 = tx_mem[s.trp[AW-1:0]];
      end
      n.bcnt = n.bcnt + 2'h1;
      n.trp = s.trp + 1'b1;
    end
    // waiting and receive mode
    if (s.st == ST_WAIT && !s.rbusy) begin
      n.tmr = s.tmr + 1'b1;
      if (s.tmr == TMO_M1) begin
        rx_we = 1'b1;
        rx_wd = `CNCC_ERR_TMO;
        n.rwp = s.rwp + 1'b1;
        n.rdy = 1'b1;
        n.st = ST_IDLE;
      end
    end
    if (s.st == ST_WAIT || s.st == ST_RX) begin
      if (!s.rbusy) begin
        if (!s.ln_s2) begin
          n.rbusy = 1'b1;
          n.rbt = HALF;
          n.rbitc = '0;
        end else if (s.st == ST_RX && clr) begin
          n.rdy = 1'b1;
          n.st = ST_IDLE;
          if (s.hdr_bad) begin
            rx_we = 1'b1;
            rx_wa = '0;
            rx_wd = `CNCC_ERR_HDR;
            n.rwp = (AW+1)'(1);
            n.rrp = '0;
          end else if (s.have_hi) begin
            rx_we = 1'b1;
            rx_wd = {s.hi, 8'h00};
            n.rwp = s.rwp + 1'b1;
          end
        end
      end else if (s.rbt != 6'h00) begin
        n.rbt = s.rbt - 6'h01;
      end else begin
        n.rbt = BIT_M1;
        n.rbitc = s.rbitc + 4'h1;
        if (s.rbitc == 4'h0 && s.ln_s2) begin
          n.rbusy = 1'b0;
        end else if (s.rbitc != 4'h0 && s.rbitc != 4'h9) begin
          n.rsh = {s.ln_s2, s.rsh[7:1]};
        end else if (s.rbitc == 4'h9) begin
          n.rbusy = 1'b0;
          n.st = ST_RX;
          n.first = 1'b0;
          if (s.nbytes < 10'(PKT_MAX)) begin
            n.nbytes = s.nbytes + 10'h001;
          end
          if (s.first) begin
            n.hdr_bad = s.rsh != `CNCC_RSP_MARK;
          end else if (!s.hdr_bad && s.nbytes < 10'(PKT_MAX)) begin
            n.have_hi = ~s.have_hi;
            n.hi = s.rsh;
            if (s.have_hi) begin
              rx_we = 1'b1;
              rx_wd = {s.hi, s.rsh};
              n.rwp = s.rwp + 1'b1;
            end
          end
        end
      end
    end
    // restart overrides mode, pointers, enables and busy flags; the function answer of the same cycle still stands
    rst_req = btn_hit || CRATE_CLR_I;
    if (CMD_STB_I && FUNC_I == `CNCC_F_RESET && s.st != ST_RESTART) begin
      rst_req = 1'b1;
    end
    if (rst_req) begin
      n.st = ST_RESTART;
      n.tmr = '0;
      n.twp = '0;
      n.trp = '0;
      n.rwp = '0;
      n.rrp = '0;
      n.lam_en = 1'b0;
      n.rdy = 1'b0;
      n.bcnt = '0;
      n.tbusy = 1'b0;
      n.rbusy = 1'b0;
    end else if (s.st == ST_RESTART) begin
      if (s.tmr != RST_M1) begin
        n.tmr = s.tmr + 1'b1;
      end else if (clr) begin
        n.st = ST_IDLE;
      end
    end
    n.lam = n.rdy && n.lam_en && n.rwp != n.rrp;
    n.led = n.st == ST_TX || n.st == ST_RX;
    n.oe_n = ~n.tbusy;
    n.dout = n.sh[0];
  end
  // -------------------------------------------------------------
  // registers and word buffers
  // -------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      s <= '0;
      s.ln_s1 <= 1'b1;
      s.ln_s2 <= 1'b1;
      s.oe_n <= 1'b1;
      s.dout <= 1'b1;
    end else if (CE_I) begin
      s <= n;
    end
  end
  always_ff @(posedge CORE_CLK_I) begin
    if (CE_I && tx_we) begin
      tx_mem[s.twp[AW-1:0]] <= WDATA_I;
    end
    if (CE_I && rx_we && !rst_req) begin
      rx_mem[rx_wa[AW-1:0]] <= rx_wd;
    end
  end
  assign DONE_O = s.done;
  assign Q_O = s.q;
  assign RDATA_O = s.rdata;
  assign LAM_O = s.lam;
  assign LED_O = s.led;
  assign line.m_oe_n = s.oe_n;
  assign line.m_dout = s.dout;
endmodule

//--- bench/cncc_checker.sv
// line checker: framing, talk order and quiet times on the coax line
// assumes the interface signals and the core clock, reset active low
`timescale 1ns/1ps
module cncc_checker (
  // clock, reset
  input  wire logic CORE_CLK_I,
  input  wire logic RST_B_I,
  // shared line
  input  wire logic m_oe_n,
  input  wire logic m_dout,
  input  wire logic s_oe_n,
  input  wire logic s_dout,
  input  wire logic line
);
  localparam int FRM = 400;
  typedef struct packed {
    logic [9:0]  idle;
    logic [9:0]  mq;
    logic [9:0]  sq;
    logic [17:0] mlen;
    logic [17:0] slen;
  } cncc_chk_t;
  cncc_chk_t st_r;
  cncc_chk_t st_nxt;
  // idle run, cycles since each end drove, drive lengths
  always_comb begin
    st_nxt = st_r;
    st_nxt.idle = line ? st_r.idle + {9'h000, st_r.idle != 10'h3e8} : '0;
    st_nxt.mq = m_oe_n ? st_r.mq + {9'h000, st_r.mq != 10'h3e8} : '0;
    st_nxt.sq = s_oe_n ? st_r.sq + {9'h000, st_r.sq != 10'h3e8} : '0;
    // lengths run over a whole packet, cleared once the end falls quiet
    st_nxt.mlen = !m_oe_n ? st_r.mlen + 18'h00001 :
                  (st_r.mq > 10'h008 ? '0 : st_r.mlen);
    st_nxt.slen = !s_oe_n ? st_r.slen + 18'h00001 :
                  (st_r.sq > 10'h008 ? '0 : st_r.slen);
  end
  // counters start as if both ends had long been quiet
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      st_r <= {10'h000, 10'h3e8, 10'h3e8, 36'h000000000};
    end else begin
      st_r <= st_nxt;
    end
  end
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RST_B_I);
  sequence s_m_start;
    !m_dout [*8];
  endsequence
  sequence s_s_start;
    !s_dout [*8];
  endsequence
  property p_one_talker;
    !(!m_oe_n && !s_oe_n);
  endproperty
  property p_m_start;
    $fell(m_oe_n) |-> s_m_start;
  endproperty
  property p_s_start;
    $fell(s_oe_n) |-> s_s_start;
  endproperty
  property p_m_frame;
    $rose(m_oe_n) |-> $past(m_dout) && st_r.mlen % FRM == 0;
  endproperty
  property p_s_frame;
    $rose(s_oe_n) |-> $past(s_dout) && st_r.slen % FRM == 0;
  endproperty
  property p_m_len;
    !m_oe_n |-> st_r.mlen < 18'h32000;
  endproperty
  property p_m_clear;
    $fell(m_oe_n) && st_r.mq > 10'h008 |-> st_r.idle >= 10'h078;
  endproperty
  property p_s_clear;
    $fell(s_oe_n) && st_r.sq > 10'h008 |->
      st_r.idle >= 10'h078 && st_r.mq < 10'h190;
  endproperty
  a_one_talker: assert property (p_one_talker)
    else $error("both ends drive the line");
  a_m_start: assert property (p_m_start)
    else $error("controller start bit too short");
  a_s_start: assert property (p_s_start)
    else $error("slave start bit too short");
  a_m_frame: assert property (p_m_frame)
    else $error("controller frame length or stop bit wrong");
  a_s_frame: assert property (p_s_frame)
    else $error("slave frame length or stop bit wrong");
  a_m_len: assert property (p_m_len)
    else $error("controller packet too long");
  a_m_clear: assert property (p_m_clear)
    else $error("controller sent before line clear");
  a_s_clear: assert property (p_s_clear)
    else $error("slave sent unprompted or too early");
endmodule

//--- bench/cncc_tb_top.sv
// bench: controller and slave node joined by one coax line
// assumes design, interface and line checker compiled before it
`timescale 1ns/1ps
`include "cncc_cfg.svh"
module cncc_tb_top;
  // -----------------------------------------------------------
  // signals and instances
  // -----------------------------------------------------------
  localparam int TMO = 20000;
  logic        clk;
  logic        rst_b;
  logic        stb;
  logic        clr;
  logic        btn;
  logic [4:0]  fn;
  logic [15:0] wd;
  logic        done;
  logic        q;
  logic [15:0] rd;
  logic        lam;
  logic        led;
  logic [7:0]  rx_byte;
  logic        rx_stb;
  logic        reply;
  logic        rep;
  logic        qv;
  logic [15:0] rv;
  logic [7:0]  rxq[$];
  logic [7:0]  exp_b[4] = '{8'h05, 8'h12, 8'h34, 8'h56};
  int          num_errors;
  int          num_checks;
  cncc_line_if line_if ();
  cncc_ctrl #(.RST_CYC(200), .TMO_CYC(TMO)) cncc_ctrl_inst (
    .CORE_CLK_I(clk), .RST_B_I(rst_b), .CE_I(1'b1),
    .CMD_STB_I(stb), .FUNC_I(fn), .WDATA_I(wd), .CRATE_CLR_I(clr),
    .DONE_O(done), .Q_O(q), .RDATA_O(rd), .LAM_O(lam),
    .PANEL_BTN_I(btn), .LED_O(led), .line(line_if.master)
  );
  cncc_slave cncc_slave_inst (
    .CORE_CLK_I(clk), .RST_B_I(rst_b), .CE_I(1'b1),
    .SLV_ADDR_I(8'h05), .RX_BYTE_O(rx_byte), .RX_STB_O(rx_stb),
    .REPLY_O(reply), .line(line_if.slave)
  );
  cncc_checker cncc_checker_inst (
    .CORE_CLK_I(clk), .RST_B_I(rst_b), .m_oe_n(line_if.m_oe_n),
    .m_dout(line_if.m_dout), .s_oe_n(line_if.s_oe_n),
    .s_dout(line_if.s_dout), .line(line_if.line)
  );
  // clock, watchdog and slave-side monitor
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    stop_test();
  end
  always @(posedge clk) begin
    if (rx_stb === 1'b1) rxq.push_back(rx_byte);
    if (reply === 1'b1) rep = 1'b1;
  end
  // -----------------------------------------------------------
  // dataway tasks
  // -----------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic chk1(input logic s, input logic e);
    check({15'h0000, s}, {15'h0000, e});
  endtask
  // one function: strobe one cycle, answer comes the cycle after
  task automatic func(input logic [4:0] f, input logic [15:0] w);
    @(posedge clk);
    #2;
    stb = 1'b1;
    fn = f;
    wd = w;
    @(posedge clk);
    #2;
    stb = 1'b0;
    chk1(done, 1'b1);
    qv = q;
    rv = rd;
  endtask
  task automatic fq(input logic [4:0] f, input logic [15:0] w,
                    input logic e);
    func(f, w);
    chk1(qv, e);
  endtask
  task automatic rdw(input logic [15:0] e);
    fq(`CNCC_F_READ, 16'h0000, 1'b1);
    check(rv, e);
  endtask
  // repeat a function until restart is over
  task automatic wait_ready(input logic [4:0] f);
    int n;
    n = 0;
    qv = 1'b0;
    while (qv !== 1'b1 && n < 600) begin
      func(f, 16'h0000);
      n++;
    end
    chk1(qv, 1'b1);
  endtask
  task automatic wait_lam();
    int n;
    n = 0;
    while (lam !== 1'b1 && n < 30000) begin
      @(posedge clk);
      #2;
      n++;
    end
    chk1(lam, 1'b1);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // -----------------------------------------------------------
  // test sequence
  // -----------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    stb = 1'b0;
    clr = 1'b0;
    btn = 1'b0;
    fn = 5'h00;
    wd = 16'h0000;
    rep = 1'b0;
    num_errors = 0;
    num_checks = 0;
    repeat (16) @(posedge clk);
    #2;
    rst_b = 1'b1;
    // power-on restart refuses functions, indicators stay off
    fq(`CNCC_F_WRITE, 16'h1111, 1'b0);
    check({14'h0000, lam, led}, 16'h0000);
    wait_ready(`CNCC_F_LAMON);
    // empty buffers, then start with nothing to send
    fq(`CNCC_F_READ, 16'h0000, 1'b0);
    fq(`CNCC_F_TEST, 16'h0000, 1'b0);
    fq(`CNCC_F_START, 16'h0000, 1'b1);
    wait_lam();
    fq(`CNCC_F_TEST, 16'h0000, 1'b1);
    rdw(`CNCC_ERR_EMPTY);
    fq(`CNCC_F_READ, 16'h0000, 1'b0);
    chk1(lam, 1'b0);
    // two-word packet to the slave, busy node refuses write and start
    rxq.delete();
    fq(`CNCC_F_WRITE, 16'h0512, 1'b1);
    fq(`CNCC_F_WRITE, 16'h3456, 1'b1);
    fq(`CNCC_F_START, 16'h0000, 1'b1);
    chk1(led, 1'b1);
    fq(`CNCC_F_WRITE, 16'h7777, 1'b0);
    fq(`CNCC_F_START, 16'h0000, 1'b0);
    wait_lam();
    chk1(led, 1'b0);
    foreach (exp_b[i]) check({8'h00, rxq[i]}, {8'h00, exp_b[i]});
    chk1(rep, 1'b1);
    rdw(16'h1234);
    rdw(16'h5600);
    fq(`CNCC_F_READ, 16'h0000, 1'b0);
    chk1(lam, 1'b0);
    // packet to an absent node times out, lam held off
    fq(`CNCC_F_LAMOFF, 16'h0000, 1'b1);
    rep = 1'b0;
    fq(`CNCC_F_WRITE, 16'h7700, 1'b1);
    fq(`CNCC_F_START, 16'h0000, 1'b1);
    repeat (TMO + 1500) @(posedge clk);
    #2;
    check({14'h0000, lam, rep}, 16'h0000);
    rdw(`CNCC_ERR_TMO);
    // fill the transmit buffer to refusal
    for (int i = 0; i < 256; i++) begin
      fq(`CNCC_F_WRITE, i[15:0], 1'b1);
    end
    fq(`CNCC_F_WRITE, 16'hbeef, 1'b0);
    // a short bounce is ignored, a held press restarts
    btn = 1'b1;
    repeat (100) @(posedge clk);
    #2;
    btn = 1'b0;
    fq(`CNCC_F_LAMON, 16'h0000, 1'b1);
    btn = 1'b1;
    repeat (`CNCC_DEB_CYC + 100) @(posedge clk);
    #2;
    btn = 1'b0;
    fq(`CNCC_F_LAMON, 16'h0000, 1'b0);
    wait_ready(`CNCC_F_START);
    repeat (4) @(posedge clk);
    #2;
    chk1(lam, 1'b0);
    rdw(`CNCC_ERR_EMPTY);
    // reset function drops a pending word
    fq(`CNCC_F_WRITE, 16'habcd, 1'b1);
    fq(`CNCC_F_RESET, 16'h0000, 1'b1);
    wait_ready(`CNCC_F_START);
    rdw(`CNCC_ERR_EMPTY);
    fq(`CNCC_F_READ, 16'h0000, 1'b0);
    // crate clear acts as the reset function
    @(posedge clk);
    #2;
    clr = 1'b1;
    @(posedge clk);
    #2;
    clr = 1'b0;
    fq(`CNCC_F_LAMON, 16'h0000, 1'b0);
    wait_ready(`CNCC_F_LAMON);
    stop_test();
  end
endmodule
